// *** verilog/sseh_error_handler.sv ***
`timescale 1ns/1ps
module sseh_error_handler (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Self-test results, one bit per test
    input wire logic st_done,
    input wire logic supply_check_fail,
    input wire logic digital_output_check_fail,
    input wire logic digital_input_check_fail,
    input wire logic analog_output_check_fail,
    input wire logic quadrature_decoder_check_fail,
    input wire logic sine_cosine_output_check_fail,
    input wire logic external_relay_monitor_fail,
    // Runtime error events and switching condition
    input wire logic [31:0] runtime_error,
    input wire logic relay_switch_cond,
    // Configuration switch sliders, 1 = on
    input wire logic [2:0] dil_slider,
    // Normal output requests
    input wire sseh_pkg::sseh_outreq_s req,
    // Safe-state outputs
    output logic relay_closed,
    output logic [15:0] aout_ua,
    output logic [sseh_pkg::NUM_DOUT-1:0] digital_output_true,
    output logic [sseh_pkg::NUM_DOUT-1:0] digital_output_inverted,
    output logic [3:0] rs422_out,
    output logic [3:0] rs422_oe,
    output logic rs422_pulldown,
    output logic sincos_offset_shift,
    output logic led_yellow,
    output logic prog_mode,
    output logic error_state
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        sseh_pkg::sseh_phase_e phase;
        logic [31:0] delay_cnt;
        logic [31:0] delay_cfg;
        logic [1:0] inj_value;
        logic inj_active;
        logic inj_armed;
        logic [31:0] prdata;
        logic relay_closed;
        logic [15:0] aout_ua;
        logic [sseh_pkg::NUM_DOUT-1:0] dout_t;
        logic [sseh_pkg::NUM_DOUT-1:0] dout_n;
        logic [3:0] rs422;
        logic [3:0] rs422_oe;
        logic rs422_pd;
        logic sincos_shift;
        logic led;
    } sseh_state_s;

    sseh_state_s st_ff;
    sseh_state_s nxt_st;

    logic [31:0] init_events;
    logic [31:0] init_code;
    logic [31:0] run_code;
    logic wr_acc;
    logic rd_acc;
    logic commit;
    logic [1:0] commit_val;
    logic any_err;
    logic monitoring;

    // ********************************************************
    // Bus decode helpers
    // ********************************************************
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == sseh_pkg::ADDR_CTRL) ||
            (a == sseh_pkg::ADDR_STATUS) ||
            (a == sseh_pkg::ADDR_INIT_CODE) ||
            (a == sseh_pkg::ADDR_RUN_CODE) ||
            (a == sseh_pkg::ADDR_DELAY);
    endfunction

    // Single-cycle access phase, never waits
    assign wr_acc = psel && penable && pwrite;
    // Read data loads in the setup cycle so it stands in the access phase
    assign rd_acc = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata = st_ff.prdata;
    assign commit = wr_acc && (paddr == sseh_pkg::ADDR_CTRL) &&
        pwdata[sseh_pkg::CTRL_COMMIT_BIT];
    assign commit_val = pwdata[sseh_pkg::CTRL_INJ_LSB +:
        sseh_pkg::CTRL_INJ_W];

    // Init failure word assembled from the individual tests
    always_comb begin
        init_events = 32'h0;
        if (supply_check_fail) begin
            init_events |= sseh_pkg::INIT_SUPPLY;
        end
        if (digital_output_check_fail) begin
            init_events |= sseh_pkg::INIT_DOUT;
        end
        if (digital_input_check_fail) begin
            init_events |= sseh_pkg::INIT_DIN;
        end
        if (analog_output_check_fail) begin
            init_events |= sseh_pkg::INIT_AOUT;
        end
        if (quadrature_decoder_check_fail) begin
            init_events |= sseh_pkg::INIT_QDEC;
        end
        if (sine_cosine_output_check_fail) begin
            init_events |= sseh_pkg::INIT_SINCOS;
        end
        if (external_relay_monitor_fail) begin
            init_events |= sseh_pkg::INIT_RELAY;
        end
    end

    // Init code latched during the power-on test phase
    sseh_code_latch u_init_latch (
        .clock(clock),
        .rst(rst),
        .enable(st_ff.phase == sseh_pkg::ST_SELFTEST && st_done),
        .events(init_events),
        .code(init_code)
    );

    // Runtime code only recorded once monitoring starts
    assign monitoring = (st_ff.phase == sseh_pkg::ST_RUN);
    sseh_code_latch u_run_latch (
        .clock(clock),
        .rst(rst),
        .enable(monitoring),
        .events(runtime_error),
        .code(run_code)
    );

    // Both classes and injection merge into one error flag
    assign any_err = (init_code != 32'h0) || (run_code != 32'h0) ||
        st_ff.inj_active;
    assign prog_mode = !dil_slider[2];

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb begin
        nxt_st = st_ff;
        // Power-on sequence
        case (st_ff.phase)
            sseh_pkg::ST_SELFTEST: begin
                if (st_done) begin
                    nxt_st.phase = sseh_pkg::ST_DELAY;
                    nxt_st.delay_cnt = 32'h0;
                end
            end
            sseh_pkg::ST_DELAY: begin
                if (st_ff.delay_cnt >= st_ff.delay_cfg) begin
                    nxt_st.phase = sseh_pkg::ST_RUN;
                end else begin
                    nxt_st.delay_cnt = st_ff.delay_cnt + 32'h1;
                end
            end
            sseh_pkg::ST_RUN: begin
                nxt_st.phase = sseh_pkg::ST_RUN;
            end
            default: begin
                nxt_st.phase = sseh_pkg::ST_SELFTEST;
            end
        endcase
        // Injection: 0 sets, 2 arms release, 1 after 2 releases
        if (commit) begin
            nxt_st.inj_value = commit_val;
            if (commit_val == sseh_pkg::INJ_SET) begin
                nxt_st.inj_active = 1'b1;
                nxt_st.inj_armed = 1'b0;
            end else if (commit_val == sseh_pkg::INJ_ARM) begin
                nxt_st.inj_armed = 1'b1;
            end else if (commit_val == sseh_pkg::INJ_RELEASE &&
                    st_ff.inj_armed) begin
                nxt_st.inj_active = 1'b0;
                nxt_st.inj_armed = 1'b0;
            end else begin
                nxt_st.inj_armed = 1'b0;
            end
        end
        if (wr_acc && paddr == sseh_pkg::ADDR_DELAY) begin
            nxt_st.delay_cfg = pwdata;
        end
        // Read data captured during the setup cycle
        if (rd_acc) begin
            case (paddr)
                sseh_pkg::ADDR_CTRL:
                    nxt_st.prdata = {30'h0, st_ff.inj_value};
                sseh_pkg::ADDR_STATUS:
                    nxt_st.prdata = {24'h0, prog_mode, st_ff.inj_armed,
                        st_ff.inj_active, run_code != 32'h0,
                        init_code != 32'h0, any_err,
                        st_ff.phase};
                sseh_pkg::ADDR_INIT_CODE: nxt_st.prdata = init_code;
                sseh_pkg::ADDR_RUN_CODE: nxt_st.prdata = run_code;
                sseh_pkg::ADDR_DELAY: nxt_st.prdata = st_ff.delay_cfg;
                default: nxt_st.prdata = 32'h0;
            endcase
        end
        // Output stage: safe values override requests
        if (any_err) begin
            nxt_st.relay_closed = 1'b0;
            nxt_st.aout_ua = sseh_pkg::AOUT_SAFE_UA;
            nxt_st.dout_t = '0;
            nxt_st.dout_n = '0;
            nxt_st.rs422 = 4'h0;
            nxt_st.rs422_oe = 4'h0;
            nxt_st.rs422_pd = 1'b0;
            nxt_st.sincos_shift = 1'b1;
            nxt_st.led = 1'b1;
        end else begin
            nxt_st.relay_closed = req.relay_closed &&
                !relay_switch_cond;
            nxt_st.aout_ua = req.aout_ua;
            nxt_st.dout_t = req.dout;
            nxt_st.dout_n = ~req.dout;
            nxt_st.rs422 = req.rs422;
            nxt_st.rs422_oe = 4'hF;
            nxt_st.rs422_pd = req.rs422_pd;
            nxt_st.sincos_shift = 1'b0;
            nxt_st.led = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.phase <= sseh_pkg::ST_SELFTEST;
            st_ff.delay_cfg <= sseh_pkg::DELAY_RESET;
            st_ff.inj_value <= sseh_pkg::INJ_RELEASE;
            st_ff.sincos_shift <= 1'b1;
            st_ff.led <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Output drive from flip-flops; error_state comes straight from any_err
    assign relay_closed = st_ff.relay_closed;
    assign aout_ua = st_ff.aout_ua;
    assign digital_output_true = st_ff.dout_t;
    assign digital_output_inverted = st_ff.dout_n;
    assign rs422_out = st_ff.rs422;
    assign rs422_oe = st_ff.rs422_oe;
    assign rs422_pulldown = st_ff.rs422_pd;
    assign sincos_offset_shift = st_ff.sincos_shift;
    assign led_yellow = st_ff.led;
    assign error_state = any_err;

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_inject_set;
        @(posedge clock) disable iff (rst)
        (commit && commit_val == sseh_pkg::INJ_SET) |=> ##1
            (led_yellow && !relay_closed);
    endproperty
    a_inject_set: assert property (p_inject_set)
        else $error("injection did not force safe state");

    property p_release_needs_arm;
        @(posedge clock) disable iff (rst)
        (commit && commit_val == sseh_pkg::INJ_RELEASE &&
            !st_ff.inj_armed && st_ff.inj_active) |=> st_ff.inj_active;
    endproperty
    a_release_needs_arm: assert property (p_release_needs_arm)
        else $error("release without arming");

    property p_aout_zero;
        @(posedge clock) disable iff (rst)
        any_err |=> (aout_ua == 16'h0);
    endproperty
    a_aout_zero: assert property (p_aout_zero)
        else $error("analog not at zero in error");

    property p_relay_open;
        @(posedge clock) disable iff (rst)
        (any_err || relay_switch_cond) |=> !relay_closed;
    endproperty
    a_relay_open: assert property (p_relay_open)
        else $error("relay closed during error or trip");

    property p_dout_low;
        @(posedge clock) disable iff (rst)
        any_err |=> (digital_output_true == '0 &&
            digital_output_inverted == '0);
    endproperty
    a_dout_low: assert property (p_dout_low)
        else $error("digital outputs not low in error");

    property p_rs422_off;
        @(posedge clock) disable iff (rst)
        any_err |=> (rs422_oe == 4'h0 && rs422_out == 4'h0 &&
            !rs422_pulldown);
    endproperty
    a_rs422_off: assert property (p_rs422_off)
        else $error("differential output active in error");

    property p_shift_led;
        @(posedge clock) disable iff (rst)
        any_err |=> (sincos_offset_shift && led_yellow);
    endproperty
    a_shift_led: assert property (p_shift_led)
        else $error("offset or indicator missing in error");

    property p_no_run_err_early;
        @(posedge clock) disable iff (rst)
        (st_ff.phase != sseh_pkg::ST_RUN) |-> (run_code == 32'h0);
    endproperty
    a_no_run_err_early: assert property (p_no_run_err_early)
        else $error("runtime error recorded during delay");

    property p_supply_bit;
        @(posedge clock) disable iff (rst)
        (st_ff.phase == sseh_pkg::ST_SELFTEST && st_done &&
            supply_check_fail) |=> init_code[2];
    endproperty
    a_supply_bit: assert property (p_supply_bit)
        else $error("supply bit not set");

endmodule // sseh_error_handler

// *** verilog/sseh_pkg.sv ***
package sseh_pkg;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INIT_CODE = 8'h08;
    localparam logic [7:0] ADDR_RUN_CODE = 8'h0C;
    localparam logic [7:0] ADDR_DELAY = 8'h10;

    // ********************************************************
    // Control register fields
    // ********************************************************
    localparam int CTRL_INJ_LSB = 0;
    localparam int CTRL_INJ_W = 2;
    localparam int CTRL_COMMIT_BIT = 8;
    localparam logic [1:0] INJ_SET = 2'h0;
    localparam logic [1:0] INJ_RELEASE = 2'h1;
    localparam logic [1:0] INJ_ARM = 2'h2;

    // ********************************************************
    // Initialization error code bits
    // ********************************************************
    localparam logic [31:0] INIT_SUPPLY = 32'h0000_0004;
    localparam logic [31:0] INIT_DOUT = 32'h0000_0010;
    localparam logic [31:0] INIT_DIN = 32'h0000_0020;
    localparam logic [31:0] INIT_AOUT = 32'h0000_0080;
    localparam logic [31:0] INIT_QDEC = 32'h0000_0100;
    localparam logic [31:0] INIT_SINCOS = 32'h0000_0200;
    localparam logic [31:0] INIT_RELAY = 32'h0000_2000;

    // ********************************************************
    // Analog output codes, timing and sizes
    // ********************************************************
    localparam logic [15:0] AOUT_SAFE_UA = 16'h0000;
    localparam logic [31:0] DELAY_RESET = 32'h0000_0100;
    localparam int NUM_DOUT = 4;
    localparam int NUM_SELF_TESTS = 7;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        ST_SELFTEST,
        ST_DELAY,
        ST_RUN
    } sseh_phase_e;

    // Self-test result from the test sequencer
    typedef struct packed {
        logic done;
        logic [NUM_SELF_TESTS-1:0] fail;
    } sseh_selftest_s;

    // Normal-mode output requests from the function logic
    typedef struct packed {
        logic relay_closed;
        logic [15:0] aout_ua;
        logic [NUM_DOUT-1:0] dout;
        logic [3:0] rs422;
        logic rs422_pd;
    } sseh_outreq_s;

endpackage

// *** verilog/sseh_code_latch.sv ***
`timescale 1ns/1ps
// Sticky per-bit latch of an error code word
module sseh_code_latch (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Event bits and enable
    input wire logic enable,
    input wire logic [31:0] events,
    // Latched code word
    output logic [31:0] code
);

    typedef struct packed {
        logic [31:0] code;
    } sseh_latch_s;

    sseh_latch_s st_ff;
    sseh_latch_s nxt_st;

    // Bits only ever set; cleared by reset alone
    always_comb begin
        nxt_st = st_ff;
        if (enable) begin
            nxt_st.code = st_ff.code | events;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign code = st_ff.code;

    property p_code_sticky;
        @(posedge clock) disable iff (rst)
        (st_ff.code != 32'h0) |=> ((st_ff.code & $past(st_ff.code))
            == $past(st_ff.code));
    endproperty
    a_code_sticky: assert property (p_code_sticky)
        else $error("latched code bit was lost");

endmodule // sseh_code_latch

// *** tb/sseh_follower.sv ***
`timescale 1ns/1ps
// Follower unit that watches the safety outputs of the monitor
module sseh_follower (
    // Safety outputs as seen at the follower's terminals
    input wire logic relay_closed,
    input wire logic [15:0] aout_ua,
    input wire logic [3:0] dout_true,
    input wire logic [3:0] dout_inv,
    input wire logic [3:0] rs422_out,
    input wire logic sincos_shift,
    input wire logic led_yellow,
    // Follower verdicts
    output logic fault_seen,
    output logic unit_ok
);
    // Fault recognised only when every output except the indicator shows its safe pattern
    assign fault_seen = !relay_closed && aout_ua == 16'h0000 &&
        dout_true == 4'h0 && dout_inv == 4'h0 && rs422_out == 4'h0 &&
        sincos_shift;
    // Unit trusted as running normally only while the indicator is dark
    assign unit_ok = !led_yellow;
endmodule // sseh_follower

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, st_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, runtime_error, rd, v;
    logic [6:0] fails;
    logic relay_switch_cond, relay_closed, rs422_pulldown, sincos_shift;
    logic led_yellow, prog_mode, error_state, fault_seen, unit_ok, e;
    logic [2:0] dil_slider;
    logic [15:0] aout_ua;
    logic [3:0] dout_t, dout_i, rs422_out, rs422_oe;
    sseh_pkg::sseh_outreq_s req;
    int err_total, tests_run;
    // Weight of each power-on test, in the order of the fails vector
    localparam logic [31:0] WGT [7] = '{
        sseh_pkg::INIT_SUPPLY,
        sseh_pkg::INIT_DOUT,
        sseh_pkg::INIT_DIN,
        sseh_pkg::INIT_AOUT,
        sseh_pkg::INIT_QDEC,
        sseh_pkg::INIT_SINCOS,
        sseh_pkg::INIT_RELAY};

    sseh_error_handler u_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .st_done(st_done), .supply_check_fail(fails[0]),
        .digital_output_check_fail(fails[1]),
        .digital_input_check_fail(fails[2]),
        .analog_output_check_fail(fails[3]),
        .quadrature_decoder_check_fail(fails[4]),
        .sine_cosine_output_check_fail(fails[5]),
        .external_relay_monitor_fail(fails[6]),
        .runtime_error(runtime_error), .relay_switch_cond(relay_switch_cond),
        .dil_slider(dil_slider), .req(req), .relay_closed(relay_closed),
        .aout_ua(aout_ua), .digital_output_true(dout_t),
        .digital_output_inverted(dout_i), .rs422_out(rs422_out),
        .rs422_oe(rs422_oe), .rs422_pulldown(rs422_pulldown),
        .sincos_offset_shift(sincos_shift), .led_yellow(led_yellow),
        .prog_mode(prog_mode), .error_state(error_state));

    sseh_follower u_follow (.relay_closed(relay_closed), .aout_ua(aout_ua),
        .dout_true(dout_t), .dout_inv(dout_i), .rs422_out(rs422_out),
        .sincos_shift(sincos_shift), .led_yellow(led_yellow),
        .fault_seen(fault_seen), .unit_ok(unit_ok));

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic logic [31:0] exp_code(input logic [6:0] f);
        logic [31:0] c;
        c = 32'h0000_0000;
        for (int i = 0; i < 7; i++) begin
            if (f[i]) begin
                c = c | WGT[i];
            end
        end
        return c;
    endfunction

    task automatic cmp(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    // Read data stands during the access phase of the same transfer
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask

    task automatic self_test(input logic [6:0] f);
        fails <= f;
        st_done <= 1'b1;
        @(posedge clock);
        st_done <= 1'b0;
        fails <= 7'h00;
        @(posedge clock);
    endtask

    // Commit an injection value, then let latch and output stage update
    task automatic inject(input logic [1:0] val);
        wr_reg(sseh_pkg::ADDR_CTRL, 32'h0000_0100 | 32'(val));
        repeat (2) @(posedge clock);
    endtask

    task automatic chk_safe(input string what);
        cmp(what, 64'({9'h000, 27'h000_0003}), 64'({relay_closed, aout_ua,
            dout_t, dout_i, rs422_out, rs422_oe, rs422_pulldown,
            sincos_shift, led_yellow}));
        cmp("follower fault", 64'h1, 64'(fault_seen));
    endtask

    task automatic chk_norm(input string what);
        cmp(what, 64'({req.relay_closed & ~relay_switch_cond, req.aout_ua,
            req.dout, ~req.dout, req.rs422, 4'hF, req.rs422_pd, 2'b00}),
            64'({relay_closed, aout_ua, dout_t, dout_i, rs422_out, rs422_oe,
            rs422_pulldown, sincos_shift, led_yellow}));
    endtask

    // ****************************************************
    // Clock, watchdog and main sequence
    // ****************************************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        st_done = 1'b0;
        fails = 7'h00;
        runtime_error = 32'h0000_0000;
        relay_switch_cond = 1'b0;
        dil_slider = 3'h7;
        req = '0;
        err_total = 0;
        tests_run = 0;
        v = $urandom(32'h4AAE444D);
        // Each power-on test alone, then random mixes, each after a reset
        for (int i = 0; i < 10; i++) begin
            do_reset();
            chk_safe("reset outputs");
            rd_reg(sseh_pkg::ADDR_DELAY, rd);
            cmp("delay reset", 64'(sseh_pkg::DELAY_RESET), 64'(rd));
            v = (i < 7) ? (32'h1 << i) : $urandom;
            self_test(v[6:0]);
            rd_reg(sseh_pkg::ADDR_INIT_CODE, rd);
            cmp("init code", 64'(exp_code(v[6:0])), 64'(rd));
            cmp("error state", 64'(|v[6:0]), 64'(error_state));
            if (v[6:0] != 7'h00) begin
                chk_safe("init error outputs");
            end
        end
        apb(1'b0, 8'h40, 32'h0000_0000, rd, e);
        cmp("unmapped error", 64'h1, 64'(e));
        // Clean start with errors raised during the power-up delay
        do_reset();
        wr_reg(sseh_pkg::ADDR_DELAY, 32'h0000_0020);
        runtime_error <= 32'hFFFF_FFFF;
        self_test(7'h00);
        repeat (4) @(posedge clock);
        runtime_error <= 32'h0000_0000;
        for (int k = 0; k < 50 && rd[1:0] != 2'h2; k++) begin
            rd_reg(sseh_pkg::ADDR_STATUS, rd);
        end
        cmp("phase run", 64'h2, 64'(rd[1:0]));
        rd_reg(sseh_pkg::ADDR_RUN_CODE, rd);
        cmp("run code masked", 64'h0, 64'(rd));
        // Random normal requests and switching conditions
        for (int i = 0; i < 8; i++) begin
            req <= sseh_pkg::sseh_outreq_s'(26'($urandom));
            relay_switch_cond <= 1'($urandom);
            repeat (3) @(posedge clock);
            chk_norm("normal outputs");
        end
        cmp("unit ok", 64'h1, 64'(unit_ok));
        // Injection: set, release without arming, arm, release
        inject(sseh_pkg::INJ_SET);
        chk_safe("injected");
        inject(sseh_pkg::INJ_RELEASE);
        chk_safe("release unarmed");
        inject(sseh_pkg::INJ_ARM);
        chk_safe("armed");
        inject(sseh_pkg::INJ_RELEASE);
        chk_norm("released");
        // One-cycle runtime error stays latched and forces safe outputs
        v = $urandom | 32'h0000_0001;
        runtime_error <= v;
        @(posedge clock);
        runtime_error <= 32'h0000_0000;
        repeat (3) @(posedge clock);
        rd_reg(sseh_pkg::ADDR_RUN_CODE, rd);
        cmp("run code", 64'(v), 64'(rd));
        chk_safe("runtime error outputs");
        // Every slider setting
        for (int s = 0; s < 8; s++) begin
            dil_slider <= 3'(s);
            @(posedge clock);
            @(posedge clock);
            cmp("prog mode", 64'(s[2] == 1'b0), 64'(prog_mode));
        end
        close_out();
    end
endmodule // testbench
